// ### verilog/dcs_datapath.sv
// Division correction steps, barrel shifts and 32-bit immediate load.
// Assumes decode issues one request per valid cycle and honours busy_o.
`timescale 1ns/10ps
`default_nettype none
module dcs_datapath
  import dcs_pkg::*;
(
  input  wire logic        ref_clk_i,          // Core clock, 200 MHz
  input  wire logic        rst_b_i,            // Async reset, active low
  input  wire logic        clk_en_i,           // Freezes all state when low
  input  wire logic        req_valid_i,        // Request present
  input  wire dcs_req_t    req_i,              // Operation and operands
  input  wire logic        md_load_i,          // Load md words from setup
  input  wire logic [31:0] md_high_in_i,       // md_high value to load
  input  wire logic [31:0] md_low_in_i,        // md_low value to load
  input  wire logic        sign_differ_in_i,   // Sign-differ flag from setup
  input  wire logic        flags_load_i,       // Load flags from outside
  input  wire dcs_flags_t  flags_in_i,         // Flags to load
  output logic [31:0]      md_high_o,          // Remainder word
  output logic [31:0]      md_low_o,           // Dividend / quotient word
  output dcs_flags_t       flags_o,            // Condition flags
  output logic             wr_en_o,            // Destination write strobe
  output logic [31:0]      wr_data_o,          // Destination write data
  output logic             busy_o,             // Immediate load in progress
  output logic             done_o              // Operation finished pulse
);

  logic [31:0] md_high;
  logic [31:0] md_low;
  logic        sign_differ;
  dcs_flags_t  flags;
  logic        wr_en;
  logic [31:0] wr_data;
  logic        done;
  logic        busy;
  logic [1:0]  imm_cnt;
  logic [31:0] imm_word_q;

  logic [31:0] next_md_high;
  logic [31:0] next_md_low;
  logic        next_sign_differ;
  dcs_flags_t  next_flags;
  logic        next_wr_en;
  logic [31:0] next_wr_data;
  logic        next_done;
  logic        next_busy;
  logic [1:0]  next_imm_cnt;
  logic [31:0] next_imm_word;

  logic [32:0] step_sum;
  logic [4:0]  sh_amt;
  dcs_dir_t    sh_dir;
  logic [31:0] sh_res;
  logic        sh_carry;
  logic        take;

  assign take = req_valid_i && (imm_cnt == 2'h0);

  // Amount select
  always_comb begin
    sh_amt = {1'b0, req_i.imm4};
    sh_dir = DCS_DIR_LEFT;
    case (req_i.op)
      DCS_OP_SHL, DCS_OP_SHRL, DCS_OP_SHRA: begin
        if (req_i.amt_from_reg) begin
          sh_amt = req_i.src_reg[SHAMT_W-1:0];
        end
      end
      DCS_OP_SHL16, DCS_OP_SHRL16, DCS_OP_SHRA16: begin
        sh_amt = {1'b0, req_i.imm4} + EXT_SHIFT_ADD;
      end
      default: begin
        sh_amt = {1'b0, req_i.imm4};
      end
    endcase
    case (req_i.op)
      DCS_OP_SHRL, DCS_OP_SHRL16: sh_dir = DCS_DIR_RIGHT;
      DCS_OP_SHRA, DCS_OP_SHRA16: sh_dir = DCS_DIR_ARITH;
      default: sh_dir = DCS_DIR_LEFT;
    endcase
  end

  dcs_shift_unit u_shift (
    .value_i  (req_i.dest_reg),
    .amount_i (sh_amt),
    .dir_i    (sh_dir),
    .result_o (sh_res),
    .carry_o  (sh_carry)
  );

  // Step-2 add or subtract with carry/borrow
  always_comb begin
    if (sign_differ) begin
      step_sum = {1'b0, md_high} + {1'b0, req_i.dest_reg};
    end else begin
      step_sum = {1'b0, md_high} - {1'b0, req_i.dest_reg};
    end
  end

  always_comb begin
    next_md_high     = md_high;
    next_md_low      = md_low;
    next_sign_differ = sign_differ;
    next_flags       = flags;
    next_wr_en       = 1'b0;
    next_wr_data     = wr_data;
    next_done        = 1'b0;
    next_imm_cnt     = imm_cnt;
    next_imm_word    = imm_word_q;
    if (md_load_i) begin
      next_md_high     = md_high_in_i;
      next_md_low      = md_low_in_i;
      next_sign_differ = sign_differ_in_i;
    end
    if (flags_load_i) begin
      next_flags = flags_in_i;
    end
    if (imm_cnt != 2'h0) begin
      next_imm_cnt = imm_cnt - 2'h1;
      if (imm_cnt == 2'h1) begin
        next_wr_en   = 1'b1;
        next_wr_data = imm_word_q;
        next_done    = 1'b1;
      end
    end else if (take) begin
      case (req_i.op)
        DCS_OP_DIV_FIX2: begin
          next_flags.zero  = (step_sum[31:0] == 32'h0);
          next_flags.carry = step_sum[32];
          if (flags.zero) begin
            next_md_high = MD_HIGH_RST;
          end
          next_done = 1'b1;
        end
        DCS_OP_DIV_FIX3: begin
          if (flags.zero) begin
            next_md_low = md_low + 32'h1;
          end
          next_done = 1'b1;
        end
        DCS_OP_DIV_FINAL: begin
          if (sign_differ) begin
            next_md_low = 32'h0 - md_low;
          end
          next_done = 1'b1;
        end
        DCS_OP_SHL, DCS_OP_SHL16, DCS_OP_SHRL, DCS_OP_SHRL16,
        DCS_OP_SHRA, DCS_OP_SHRA16: begin
          next_wr_en       = 1'b1;
          next_wr_data     = sh_res;
          next_flags.zero  = (sh_res == 32'h0);
          next_flags.negative = sh_res[31];
          if (req_i.op == DCS_OP_SHRL16) begin
            next_flags.negative = 1'b0;
          end
          next_flags.carry = sh_carry;
          next_done        = 1'b1;
        end
        DCS_OP_LOAD_IMM: begin
          next_imm_cnt  = LOAD_IMM_CYCLES - 2'h1;
          next_imm_word = req_i.imm_word;
        end
        default: begin
          next_done = 1'b0;
        end
      endcase
    end
    next_busy = (next_imm_cnt != 2'h0);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      md_high     <= MD_HIGH_RST;
      md_low      <= MD_LOW_RST;
      sign_differ <= FLAG_RST;
      flags       <= '0;
      wr_en       <= 1'b0;
      wr_data     <= 32'h0;
      done        <= 1'b0;
      busy        <= 1'b0;
      imm_cnt     <= 2'h0;
      imm_word_q  <= 32'h0;
    end else if (clk_en_i) begin
      md_high     <= next_md_high;
      md_low      <= next_md_low;
      sign_differ <= next_sign_differ;
      flags       <= next_flags;
      wr_en       <= next_wr_en;
      wr_data     <= next_wr_data;
      done        <= next_done;
      busy        <= next_busy;
      imm_cnt     <= next_imm_cnt;
      imm_word_q  <= next_imm_word;
    end
  end

  assign md_high_o = md_high;
  assign md_low_o  = md_low;
  assign flags_o   = flags;
  assign wr_en_o   = wr_en;
  assign wr_data_o = wr_data;
  assign busy_o    = busy;
  assign done_o    = done;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_fix2_zero: assert property (
    clk_en_i && take && !md_load_i && !flags_load_i
      && req_i.op == DCS_OP_DIV_FIX2
    |=> flags.zero == ($past(step_sum[31:0]) == 32'h0)
  ) else $error("step two zero flag wrong");

  chk_fix2_clear: assert property (
    clk_en_i && take && !md_load_i && req_i.op == DCS_OP_DIV_FIX2
      && flags.zero
    |=> md_high == 32'h0
  ) else $error("step two did not clear md_high");

  chk_fix3_inc: assert property (
    clk_en_i && take && !md_load_i && req_i.op == DCS_OP_DIV_FIX3
    |=> md_low == $past(md_low) + ($past(flags.zero) ? 32'h1 : 32'h0)
  ) else $error("step three increment wrong");

  chk_final_neg: assert property (
    clk_en_i && take && !md_load_i && req_i.op == DCS_OP_DIV_FINAL
      && sign_differ
    |=> md_low == 32'h0 - $past(md_low)
  ) else $error("final fix negation wrong");

  chk_div_flags: assert property (
    clk_en_i && take && !flags_load_i
      && (req_i.op == DCS_OP_DIV_FIX3 || req_i.op == DCS_OP_DIV_FINAL)
    |=> $stable(flags)
  ) else $error("step three or final fix changed flags");

  chk_shift_cycle: assert property (
    clk_en_i && take && (req_i.op inside {DCS_OP_SHL, DCS_OP_SHL16,
      DCS_OP_SHRL, DCS_OP_SHRL16, DCS_OP_SHRA, DCS_OP_SHRA16})
    |=> wr_en && done
  ) else $error("shift not done in one cycle");

  chk_shrl16_neg: assert property (
    clk_en_i && take && !flags_load_i && req_i.op == DCS_OP_SHRL16
    |=> !flags.negative
  ) else $error("extended right shift left negative set");

  chk_shift_zero: assert property (
    clk_en_i && take && !flags_load_i && (req_i.op inside {DCS_OP_SHL,
      DCS_OP_SHL16, DCS_OP_SHRL, DCS_OP_SHRL16, DCS_OP_SHRA, DCS_OP_SHRA16})
    |=> flags.zero == (wr_data == 32'h0) && $stable(flags.overflow)
  ) else $error("shift zero flag mismatch");

  chk_zero_amt: assert property (
    clk_en_i && take && !flags_load_i
      && (req_i.op inside {DCS_OP_SHL, DCS_OP_SHRL, DCS_OP_SHRA})
      && sh_amt == 5'h0
    |=> !flags.carry && wr_data == $past(req_i.dest_reg)
  ) else $error("zero shift carry not cleared");

  chk_load_imm_cycles: assert property (
    clk_en_i && take && req_i.op == DCS_OP_LOAD_IMM
    ##1 clk_en_i [*2]
    |-> ##1 wr_en && !$past(wr_en)
  ) else $error("immediate load timing wrong");

  cov_fix2:     cover property (take && clk_en_i
                                && req_i.op == DCS_OP_DIV_FIX2);
  cov_shra:     cover property (take && clk_en_i
                                && req_i.op == DCS_OP_SHRA16);
  cov_load_imm: cover property (take && clk_en_i
                                && req_i.op == DCS_OP_LOAD_IMM);
  cov_final:    cover property (take && clk_en_i
                                && req_i.op == DCS_OP_DIV_FINAL
                                && sign_differ);

endmodule : dcs_datapath
`default_nettype wire

// ### inc/dcs_pkg.sv
// Package for the division-correction and shifter datapath.
// Assumes a single core clock; shared by the datapath and its shift unit.
package dcs_pkg;

  localparam int unsigned DATA_W        = 32;
  localparam int unsigned SHAMT_W       = 5;
  localparam int unsigned IMM4_W        = 4;
  localparam logic [4:0]  EXT_SHIFT_ADD = 5'h10;
  localparam logic [31:0] MD_HIGH_RST   = 32'h0000_0000;
  localparam logic [31:0] MD_LOW_RST    = 32'h0000_0000;
  localparam logic        FLAG_RST      = 1'b0;
  // Cycles an immediate word load occupies
  localparam logic [1:0]  LOAD_IMM_CYCLES = 2'h3;

  typedef enum logic [3:0] {
    DCS_OP_NONE      = 4'h0,
    DCS_OP_DIV_FIX2  = 4'h1,
    DCS_OP_DIV_FIX3  = 4'h2,
    DCS_OP_DIV_FINAL = 4'h3,
    DCS_OP_SHL       = 4'h4,
    DCS_OP_SHL16     = 4'h5,
    DCS_OP_SHRL      = 4'h6,
    DCS_OP_SHRL16    = 4'h7,
    DCS_OP_SHRA      = 4'h8,
    DCS_OP_SHRA16    = 4'h9,
    DCS_OP_LOAD_IMM  = 4'ha
  } dcs_op_t;

  typedef enum logic [1:0] {
    DCS_DIR_LEFT  = 2'h0,
    DCS_DIR_RIGHT = 2'h1,
    DCS_DIR_ARITH = 2'h2
  } dcs_dir_t;

  typedef struct packed {
    logic negative;
    logic zero;
    logic overflow;
    logic carry;
  } dcs_flags_t;

  typedef struct packed {
    dcs_op_t     op;
    logic        amt_from_reg;
    logic [3:0]  imm4;
    logic [31:0] dest_reg;
    logic [31:0] src_reg;
    logic [31:0] imm_word;
  } dcs_req_t;

endpackage : dcs_pkg

// ### verilog/dcs_shift_unit.sv
// Combinational barrel shifter with last-bit-out carry.
// Assumes the caller registers the outputs.
`timescale 1ns/10ps
`default_nettype none
module dcs_shift_unit
  import dcs_pkg::*;
(
  input  wire logic [31:0] value_i,  // Word to shift
  input  wire logic [4:0]  amount_i, // Effective amount 0..31
  input  wire dcs_dir_t    dir_i,    // Direction and fill
  output logic      [31:0] result_o, // Shifted word
  output logic             carry_o   // Last bit shifted out
);

  logic [32:0] wide;

  always_comb begin
    wide     = 33'h0;
    result_o = 32'h0;
    carry_o  = 1'b0;
    case (dir_i)
      DCS_DIR_LEFT: begin
        wide     = {1'b0, value_i} << amount_i;
        result_o = wide[31:0];
        carry_o  = (amount_i == 5'h0) ? 1'b0 : wide[32];
      end
      DCS_DIR_RIGHT, DCS_DIR_ARITH: begin
        if (dir_i == DCS_DIR_ARITH) begin
          result_o = 32'($signed(value_i) >>> amount_i);
        end else begin
          result_o = value_i >> amount_i;
        end
        // Zero amount leaves carry clear
        if (amount_i != 5'h0) begin
          carry_o = value_i[amount_i - 5'h1];
        end
      end
      default: begin
        result_o = value_i;
        carry_o  = 1'b0;
      end
    endcase
  end

endmodule : dcs_shift_unit
`default_nettype wire

// ### tb/dcs_regfile_model.sv
// Register-file stand-in: keeps the last word written back.
// Assumes one write strobe per result from the datapath.
`timescale 1ns/10ps
`default_nettype none
module dcs_regfile_model (
  input  wire logic        ref_clk_i, // Core clock
  input  wire logic        rst_b_i,   // Async reset, active low
  input  wire logic        wr_en_i,   // Write strobe
  input  wire logic [31:0] wr_data_i, // Write data
  output logic      [31:0] dest_o     // Destination register
);
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dest_o <= 32'h0000_0000;
    end else if (wr_en_i) begin
      dest_o <= wr_data_i;
    end
  end
endmodule : dcs_regfile_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the division-correction and shift datapath.
// Assumes dcs_pkg is compiled first; drives inputs on falling edges.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dcs_pkg::*;
;
  logic        ref_clk   = 1'b0;
  logic        rst_b     = 1'b0;
  logic        clk_en    = 1'b1;
  logic        req_valid = 1'b0;
  dcs_req_t    req       = '0;
  logic        md_load   = 1'b0;
  logic [31:0] md_hi_in  = 32'h0;
  logic [31:0] md_lo_in  = 32'h0;
  logic        sd_in     = 1'b0;
  logic        fl_load   = 1'b0;
  dcs_flags_t  fl_in     = '0;
  logic [31:0] md_high, md_low, wr_data, dest;
  dcs_flags_t  flags, exp_fl;
  logic        wr_en, busy, done;
  int          error_cnt = 0;
  int          checked   = 0;
  int          cycles    = 0;

  always #2.5 ref_clk = ~ref_clk;

  dcs_datapath dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .clk_en_i(clk_en), .req_valid_i(req_valid), .req_i(req),
    .md_load_i(md_load), .md_high_in_i(md_hi_in),
    .md_low_in_i(md_lo_in), .sign_differ_in_i(sd_in),
    .flags_load_i(fl_load), .flags_in_i(fl_in), .md_high_o(md_high),
    .md_low_o(md_low), .flags_o(flags), .wr_en_o(wr_en),
    .wr_data_o(wr_data), .busy_o(busy), .done_o(done));

  dcs_regfile_model rf (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .wr_en_i(wr_en), .wr_data_i(wr_data), .dest_o(dest));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic issue(input dcs_op_t op, input logic fr,
                       input logic [3:0] i4, input logic [31:0] d, s);
    req = '{op, fr, i4, d, s, d};
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    req.op = DCS_OP_NONE;
  endtask : issue

  task automatic preload(input logic [31:0] hi, lo, input logic sd,
                         input dcs_flags_t f);
    md_hi_in = hi;
    md_lo_in = lo;
    sd_in = sd;
    fl_in = f;
    md_load = 1'b1;
    fl_load = 1'b1;
    @(negedge ref_clk);
    md_load = 1'b0;
    fl_load = 1'b0;
    exp_fl = f;
  endtask : preload

  task automatic shift_case(input dcs_op_t op, input logic fr,
                            input logic [3:0] i4, input logic [31:0] d, s);
    logic [4:0]  n;
    logic [63:0] w;
    logic [31:0] r;
    logic        c;
    n = fr ? s[4:0] : {1'b0, i4};
    if (op inside {DCS_OP_SHL16, DCS_OP_SHRL16, DCS_OP_SHRA16})
      n = {1'b1, i4};
    if (op inside {DCS_OP_SHL, DCS_OP_SHL16}) begin
      w = {32'h0, d} << n;
      r = w[31:0];
      c = w[32];
    end else begin
      if (op inside {DCS_OP_SHRA, DCS_OP_SHRA16})
        w = $signed({d, 32'h0}) >>> n;
      else
        w = {d, 32'h0} >> n;
      r = w[63:32];
      c = w[31];
    end
    exp_fl.negative = (op == DCS_OP_SHRL16) ? 1'b0 : r[31];
    exp_fl.zero = (r == 32'h0);
    exp_fl.carry = c;
    issue(op, fr, i4, d, s);
    chk("sh_wr_en", {31'h0, wr_en}, 32'h1);
    chk("sh_done", {31'h0, done}, 32'h1);
    chk("sh_data", wr_data, r);
    chk("sh_flags", {28'h0, flags}, {28'h0, exp_fl});
    @(negedge ref_clk);
    chk("sh_dest", dest, r);
  endtask : shift_case

  task automatic div_case(input logic [31:0] hi, lo, dv,
                          input logic sd, zo);
    logic [32:0] t;
    logic [31:0] q;
    preload(hi, lo, sd, {1'b1, zo, 1'b1, 1'b0});
    t = sd ? {1'b0, hi} + {1'b0, dv} : {1'b0, hi} - {1'b0, dv};
    exp_fl.zero = (t[31:0] == 32'h0);
    exp_fl.carry = t[32];
    issue(DCS_OP_DIV_FIX2, 1'b0, 4'h0, dv, 32'h0);
    chk("d2_md_high", md_high, zo ? 32'h0 : hi);
    chk("d2_flags", {28'h0, flags}, {28'h0, exp_fl});
    chk("d2_done", {31'h0, done}, 32'h1);
    q = exp_fl.zero ? lo + 32'h1 : lo;
    // Let an edge pass so the strobe is not lowered and raised at once
    @(negedge ref_clk);
    issue(DCS_OP_DIV_FIX3, 1'b0, 4'h0, 32'h0, 32'h0);
    chk("d3_md_low", md_low, q);
    chk("d3_flags", {28'h0, flags}, {28'h0, exp_fl});
    chk("d3_done", {31'h0, done}, 32'h1);
    if (sd)
      q = 32'h0 - q;
    @(negedge ref_clk);
    issue(DCS_OP_DIV_FINAL, 1'b0, 4'h0, 32'h0, 32'h0);
    chk("d4_md_low", md_low, q);
    chk("d4_flags", {28'h0, flags}, {28'h0, exp_fl});
  endtask : div_case

  task automatic load_imm_case;
    preload(32'h0, 32'h0, 1'b0, 4'h9);
    req = '{DCS_OP_LOAD_IMM, 1'b0, 4'h0, 32'h0, 32'h0, 32'h8765_4321};
    req_valid = 1'b1;
    @(negedge ref_clk);
    chk("imm_busy1", {31'h0, busy}, 32'h1);
    // Shift offered while busy; strobe stays up and must be ignored
    req = '{DCS_OP_SHL, 1'b0, 4'h1, 32'h1, 32'h0, 32'h0};
    @(negedge ref_clk);
    req_valid = 1'b0;
    chk("imm_busy2", {30'h0, busy, wr_en}, 32'h2);
    @(negedge ref_clk);
    chk("imm_end", {29'h0, busy, wr_en, done}, 32'h3);
    chk("imm_data", wr_data, 32'h8765_4321);
    chk("imm_flags", {28'h0, flags}, 32'h9);
    @(negedge ref_clk);
    chk("imm_dest", dest, 32'h8765_4321);
    chk("imm_refused", {31'h0, wr_en}, 32'h0);
  endtask : load_imm_case

  task automatic reset_case;
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    chk("rst_md_high", md_high, MD_HIGH_RST);
    chk("rst_md_low", md_low, MD_LOW_RST);
    chk("rst_flags", {28'h0, flags}, {28'h0, {4{FLAG_RST}}});
    chk("rst_busy", {30'h0, busy, wr_en}, 32'h0);
  endtask : reset_case

  task automatic freeze_case;
    clk_en = 1'b0;
    issue(DCS_OP_SHL, 1'b0, 4'h3, 32'h1, 32'h0);
    clk_en = 1'b1;
    chk("frozen", {27'h0, wr_en, flags}, 32'h9);
  endtask : freeze_case

  initial begin
    reset_case();
    preload(32'h0, 32'h0, 1'b0, 4'h2);
    shift_case(DCS_OP_SHL, 1'b1, 4'h0, 32'h8000_0001, 32'hffff_ffe1);
    shift_case(DCS_OP_SHL, 1'b0, 4'hf, 32'h0001_ffff, 32'h0);
    shift_case(DCS_OP_SHL16, 1'b0, 4'hf, 32'h0000_0001, 32'h0);
    shift_case(DCS_OP_SHRL, 1'b1, 4'h0, 32'h8000_0000, 32'h0000_0020);
    shift_case(DCS_OP_SHRL, 1'b0, 4'h4, 32'h0000_000f, 32'h0);
    shift_case(DCS_OP_SHRA, 1'b1, 4'h0, 32'h8000_0000, 32'h0000_001f);
    shift_case(DCS_OP_SHRL16, 1'b0, 4'h0, 32'hffff_0000, 32'h0);
    shift_case(DCS_OP_SHRA, 1'b0, 4'h0, 32'h8000_0001, 32'h0);
    shift_case(DCS_OP_SHRA16, 1'b0, 4'hf, 32'h4000_0000, 32'h0);
    // Setup load, then steps two, three and final
    div_case(32'h5, 32'h1234_5678, 32'hffff_fffb, 1'b1, 1'b1);
    div_case(32'h3, 32'h7, 32'h5, 1'b0, 1'b0);
    div_case(32'h5, 32'h9, 32'h4, 1'b0, 1'b1);
    load_imm_case();
    freeze_case();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
